/* File: rers_sequencer.sv */
`timescale 1ns/10ps
`include "rers_regs.svh"

module rers_sequencer
  import rers_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYC = `RERS_POR_HOLD_CYC
) (
  input  wire logic      clk_in,      // 250 MHz clock
  input  wire logic      rst_n_in,    // sync reset, active low
  input  wire logic      supplies_good_in, // core and io supply past threshold
  input  wire rers_req_t req_in,      // asynchronous host requests
  output rers_ctl_t      ctl_out,     // regulator enable and section resets
  output logic           por_active_out // internal power-on reset held
);

  // ****************************************
  // input synchronisers
  // ****************************************
  rers_req_t req_meta_reg;
  rers_req_t req_sync_reg;
  logic      good_meta_reg;
  logic      good_sync_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_meta_reg  <= '0;
      req_sync_reg  <= '0;
      good_meta_reg <= 1'b0;
      good_sync_reg <= 1'b0;
    end else begin
      req_meta_reg  <= req_in;
      req_sync_reg  <= req_meta_reg;
      good_meta_reg <= supplies_good_in;
      good_sync_reg <= good_meta_reg;
    end
  end

  // ****************************************
  // power-on reset counter
  // ****************************************
  // counter width covers the full default hold; parameter may shrink it
  localparam int unsigned CW = $clog2(POR_HOLD_CYC + 1);
  localparam logic [CW-1:0] POR_LAST = CW'(POR_HOLD_CYC - 1);

  logic [CW-1:0] por_cnt_reg;
  logic [CW-1:0] por_cnt_next;
  rers_state_t   state_reg;
  rers_state_t   state_next;

  wire logic any_req  = req_sync_reg.wlan_power_request |
                        req_sync_reg.bluetooth_power_request;
  wire logic por_done = (por_cnt_reg == POR_LAST);

  // supplies dropping restarts the hold; hold never exceeds POR_HOLD_CYC
  always_comb begin
    state_next   = state_reg;
    por_cnt_next = por_cnt_reg;
    case (state_reg)
      RERS_OFF: begin
        por_cnt_next = '0;
        if (good_sync_reg) state_next = RERS_HOLD;
      end
      RERS_HOLD: begin
        por_cnt_next = por_cnt_reg + CW'(1);
        if (!good_sync_reg) state_next = RERS_OFF;
        else if (por_done) state_next = RERS_RUN;
      end
      RERS_RUN: begin
        if (!good_sync_reg) state_next = RERS_OFF;
      end
      default: state_next = RERS_OFF;
    endcase
  end

  // ****************************************
  // outputs
  // ****************************************
  wire logic       run_next = (state_next == RERS_RUN);
  wire rers_ctl_t  ctl_next = '{
    regulators_enable: any_req,
    wlan_reset_n: run_next & req_sync_reg.wlan_power_request,
    bluetooth_reset_n: run_next &
                       req_sync_reg.bluetooth_power_request
  };

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg      <= RERS_OFF;
      por_cnt_reg    <= '0;
      ctl_out        <= '0;
      por_active_out <= 1'b1;
    end else begin
      state_reg      <= state_next;
      por_cnt_reg    <= por_cnt_next;
      ctl_out        <= ctl_next;
      por_active_out <= !run_next;
    end
  end

  // ****************************************
  // checks: regulator enable
  // ****************************************
  reg_or_both_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ##1 ctl_out.regulators_enable == $past(any_req))
    else $error("regulator enable not the or of requests");
  reg_on_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    any_req |=> ctl_out.regulators_enable)
    else $error("regulators off with a request high");
  reg_off_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !any_req |=> !ctl_out.regulators_enable)
    else $error("regulators on with both requests low");
  sync_req_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    req_sync_reg == $past(req_meta_reg))
    else $error("request synchroniser skipped a stage");

  // ****************************************
  // checks: section resets
  // ****************************************
  wlan_reset_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !req_sync_reg.wlan_power_request |=> !ctl_out.wlan_reset_n)
    else $error("wlan released while its request low");
  wlan_release_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_RUN && good_sync_reg &&
     req_sync_reg.wlan_power_request) |=> ctl_out.wlan_reset_n)
    else $error("wlan held in reset while requested");
  wlan_power_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ctl_out.wlan_reset_n |-> ctl_out.regulators_enable)
    else $error("wlan out of reset with regulators off");
  bt_reset_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !req_sync_reg.bluetooth_power_request |=>
      !ctl_out.bluetooth_reset_n)
    else $error("bluetooth released while its request low");
  bt_release_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_RUN && good_sync_reg &&
     req_sync_reg.bluetooth_power_request) |=> ctl_out.bluetooth_reset_n)
    else $error("bluetooth held in reset while requested");
  bt_power_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ctl_out.bluetooth_reset_n |-> ctl_out.regulators_enable)
    else $error("bluetooth out of reset with regulators off");

  // ****************************************
  // checks: power-on reset
  // ****************************************
  // ages the synchronised supply flag, one bit wider than the hold counter
  // so that one past the hold still fits; past the hold the reset is gone
  localparam int unsigned   AW      = CW + 1;
  localparam logic [AW-1:0] AGE_TOP = AW'(POR_HOLD_CYC);

  logic [AW-1:0] good_age_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !good_sync_reg) begin
      good_age_reg <= '0;
    end else if (good_age_reg <= AGE_TOP) begin
      good_age_reg <= good_age_reg + AW'(1);
    end
  end

  sync_good_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    good_sync_reg == $past(good_meta_reg))
    else $error("supply synchroniser skipped a stage");
  hold_start_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_OFF && good_sync_reg) |=>
      (state_reg == RERS_HOLD && por_cnt_reg == '0))
    else $error("hold did not start from zero");
  hold_count_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_HOLD && good_sync_reg && !por_done) |=>
      (state_reg == RERS_HOLD &&
       por_cnt_reg == $past(por_cnt_reg) + CW'(1)))
    else $error("hold counter did not advance");
  por_bound_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_HOLD) |-> por_cnt_reg < CW'(POR_HOLD_CYC))
    else $error("power-on reset held too long");
  por_exit_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_HOLD && por_done && good_sync_reg) |=>
      (state_reg == RERS_RUN && !por_active_out))
    else $error("power-on reset not released at hold end");
  por_limit_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (good_age_reg > AGE_TOP) |-> !por_active_out)
    else $error("power-on reset outlived the hold");
  por_restart_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg != RERS_OFF && !good_sync_reg) |=> (state_reg == RERS_OFF))
    else $error("supply loss did not restart the hold");
  off_stay_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_OFF && !good_sync_reg) |=> (state_reg == RERS_OFF))
    else $error("hold started without supplies");
  run_stay_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == RERS_RUN && good_sync_reg) |=>
      (state_reg == RERS_RUN && !por_active_out))
    else $error("power-on reset came back with supplies good");
  hold_reset_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_reg != RERS_RUN) |->
      (!ctl_out.wlan_reset_n && !ctl_out.bluetooth_reset_n))
    else $error("section released before the hold ended");
  por_sections_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    por_active_out |->
      (!ctl_out.wlan_reset_n && !ctl_out.bluetooth_reset_n))
    else $error("section released during power-on reset");

endmodule : rers_sequencer

/* File: rers_regs.svh */
`ifndef RERS_REGS_SVH
`define RERS_REGS_SVH

// longest internal power-on reset hold after both supplies are good
`define RERS_POR_HOLD_MS     110
// least wait before the first bus access after supplies are available
`define RERS_BUS_WAIT_MS     150
// least off time between toggles, lets the buck regulator discharge; not enforced here, regulators_enable follows the requests at once
`define RERS_DISCHARGE_MS    10
`define RERS_CLK_KHZ         250000
`define RERS_POR_HOLD_CYC    (`RERS_POR_HOLD_MS * `RERS_CLK_KHZ)
`define RERS_DISCHARGE_CYC   (`RERS_DISCHARGE_MS * `RERS_CLK_KHZ)

`endif

/* File: rers_pkg.sv */
package rers_pkg;

  typedef struct packed {
    logic wlan_power_request;
    logic bluetooth_power_request;
  } rers_req_t;

  typedef struct packed {
    logic regulators_enable;
    logic wlan_reset_n;
    logic bluetooth_reset_n;
  } rers_ctl_t;

  // gray coded along off -> hold -> run
  typedef enum logic [1:0] {
    RERS_OFF  = 2'b00,
    RERS_HOLD = 2'b01,
    RERS_RUN  = 2'b11
  } rers_state_t;

endpackage : rers_pkg

/* File: rers_host_model.sv */
`timescale 1ns/10ps
module rers_host_model
  import rers_pkg::*;
(
  input  wire logic clk_in,   // bench clock
  input  wire logic rst_n_in, // host reset, active low
  input  wire logic wlan_in,  // wlan wanted
  input  wire logic bt_in,    // bluetooth wanted
  input  wire logic fm_in,    // fm wanted
  output rers_req_t req_out   // requests to device
);
  // gpio moves off the device's sampling edge
  always_ff @(negedge clk_in) begin
    if (!rst_n_in) begin
      req_out <= '0;
    end else begin
      req_out.wlan_power_request      <= wlan_in;
      req_out.bluetooth_power_request <= bt_in | fm_in;
    end
  end
endmodule : rers_host_model

/* File: rers_sequencer_tb.sv */
`timescale 1ns/10ps
module rers_sequencer_tb
  import rers_pkg::*;
;
  logic      clk_in = 1'b0, rst_n_in = 1'b0, good = 1'b0;
  logic      w = 1'b0, b = 1'b0, f = 1'b0, por;
  rers_req_t req;
  rers_ctl_t ctl;
  int        miscompares = 0, check_count = 0;
  // scaled stand-ins: the 110 ms hold as 20 cycles, the 150 ms wait as 28
  localparam int HOLD     = 20;
  localparam int BUS_WAIT = 28;
  always #2 clk_in = ~clk_in;
  rers_host_model host_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wlan_in(w), .bt_in(b), .fm_in(f), .req_out(req));
  rers_sequencer #(.POR_HOLD_CYC(HOLD)) dut_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .supplies_good_in(good), .req_in(req),
    .ctl_out(ctl), .por_active_out(por));
  task automatic chk(input string what, input logic [3:0] exp, got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // six edges cover model relay plus sync and output flops
  task automatic req_set(input logic wl, bl, fl, input logic [3:0] exp);
    w <= wl;
    b <= bl;
    f <= fl;
    repeat (6) @(negedge clk_in);
    chk("ctl_por", exp, {ctl, por});
  endtask : req_set
  task automatic por_release;
    int n;
    good <= 1'b1;
    req_set(1'b1, 1'b1, 1'b0, 4'h9);
    n = 6;
    // the host's bus wait bounds the loop; still in reset past it fails
    while (n < BUS_WAIT && por !== 1'b0) begin
      @(negedge clk_in);
      n++;
    end
    chk("por_done", 4'h0, {3'h0, por});
    chk("por_hold", 4'h1, {3'h0, n >= HOLD && n <= HOLD + 3});
    if (por !== 1'b0) wrap_up();
    chk("ctl_run", 4'he, {ctl, por});
  endtask : por_release
  task automatic sections;
    req_set(1'b1, 1'b0, 1'b0, 4'hc);
    req_set(1'b0, 1'b0, 1'b1, 4'ha);
    req_set(1'b0, 1'b0, 1'b0, 4'h0);
    // off time stands in for the discharge wait, as long as the scaled hold
    repeat (20) @(negedge clk_in);
    req_set(1'b0, 1'b1, 1'b0, 4'ha);
  endtask : sections
  task automatic supply_drop;
    good <= 1'b0;
    req_set(1'b1, 1'b1, 1'b0, 4'h9);
  endtask : supply_drop
  //****************************************
  // main sequence
  //****************************************
  initial begin
    repeat (8) @(negedge clk_in);
    chk("in_reset", 4'h1, {ctl, por});
    rst_n_in <= 1'b1;
    por_release();
    sections();
    supply_drop();
    wrap_up();
  end
endmodule : rers_sequencer_tb
